//--- logic/twowire_own_id_and_recovery.sv
// Own identity match, bus occupancy and line recovery of the two-wire unit
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module twowire_own_id_and_recovery
    import twowire_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [2:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    output logic             irq_o
);
    logic                 rst_meta_ff;
    logic                 rst_n_ff;
    logic                 sda_sync;
    logic                 scl_sync;
    logic                 sda_prev_ff;
    logic                 scl_prev_ff;
    logic                 waitrequest_ff;
    logic [31:0]          readdata_ff;
    logic                 enable_ff;
    logic [1:0]           ctl1_ff;
    logic                 clock_line_pulse_ff;
    logic                 bb_ff;
    logic                 match_ff;
    logic                 busy_ff;
    logic                 master_ff;
    logic [7:0]           own_id_ff;
    logic [IRQ_WIDTH-1:0] irq_status_ff;
    logic [IRQ_WIDTH-1:0] irq_mask_ff;
    logic                 irq_ff;
    logic                 sda_oe_ff;
    logic                 scl_oe_ff;
    line_state_type       line_state_ff;
    logic [CNT_WIDTH-1:0] line_cnt_ff;
    logic [CNT_WIDTH-1:0] idle_cnt_ff;
    logic                 bus_quiet_ff;
    logic                 addr_phase_ff;
    logic [3:0]           bit_cnt_ff;
    logic [7:0]           shift_ff;

    logic                 wr_acc;
    logic                 rd_acc;
    logic                 start_cond;
    logic                 stop_cond;
    logic                 scl_rise;
    logic                 half_done;
    logic                 addr_done;
    logic                 id_hit;
    logic [7:0]           addr_byte;
    logic [IRQ_WIDTH-1:0] irq_events;

    // Reset release through two flops
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    level_sync u_sda_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_ff),
        .async_i    (sda_i),
        .sync_o     (sda_sync)
    );

    level_sync u_scl_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_ff),
        .async_i    (scl_i),
        .sync_o     (scl_sync)
    );

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sda_prev_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
        end else begin
            sda_prev_ff <= sda_sync;
            scl_prev_ff <= scl_sync;
        end
    end

    assign start_cond = enable_ff && scl_sync && scl_prev_ff && sda_prev_ff && !sda_sync;
    assign stop_cond  = enable_ff && scl_sync && scl_prev_ff && !sda_prev_ff && sda_sync;
    assign scl_rise   = scl_sync && !scl_prev_ff;
    assign half_done  = (line_cnt_ff == CNT_WIDTH'(SCL_HALF_CYC - 1));

    // Avalon-MM slave: one wait cycle, then accept
    assign wr_acc = write_i && !waitrequest_ff;
    assign rd_acc = read_i && !waitrequest_ff;

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            waitrequest_ff <= 1'b1;
        end else begin
            waitrequest_ff <= !(waitrequest_ff && (read_i || write_i));
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            readdata_ff <= 32'h0000_0000;
        end else if (read_i && waitrequest_ff) begin
            readdata_ff <= 32'h0000_0000;
            unique case (address_i)
                REG_CONTROL_TWO_IDX: readdata_ff[BIT_ENABLE] <= enable_ff;
                REG_CONTROL_ONE_IDX: readdata_ff[1:0] <= ctl1_ff;
                REG_CONTROL_STAT_IDX: begin
                    readdata_ff[BIT_BUSY]  <= busy_ff;
                    readdata_ff[BIT_BB]    <= bb_ff;
                    readdata_ff[BIT_MATCH] <= match_ff;
                    readdata_ff[BIT_DATA_LINE_SAMPLE]  <= sda_sync;
                    readdata_ff[BIT_CLOCK_LINE_PULSE] <= clock_line_pulse_ff;
                end
                REG_OWN_ID_IDX: readdata_ff[7:0] <= own_id_ff;
                REG_STATUS_IDX: begin
                    readdata_ff[BIT_MASTER]    <= master_ff;
                    readdata_ff[BIT_BUS_QUIET] <= bus_quiet_ff;
                end
                REG_IRQ_STATUS_IDX: readdata_ff[IRQ_WIDTH-1:0] <= irq_status_ff;
                REG_IRQ_MASK_IDX: readdata_ff[IRQ_WIDTH-1:0] <= irq_mask_ff;
                default: readdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Enable and identity registers
    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            enable_ff <= 1'b0;
        end else if (wr_acc && address_i == REG_CONTROL_TWO_IDX) begin
            enable_ff <= writedata_i[BIT_ENABLE];
        end
    end

    // Identity keeps no reset value
    always_ff @(posedge core_clk_i) begin
        if (wr_acc && address_i == REG_OWN_ID_IDX) begin
            own_id_ff <= writedata_i[7:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            irq_mask_ff <= IRQ_RESET;
        end else if (wr_acc && address_i == REG_IRQ_MASK_IDX) begin
            irq_mask_ff <= writedata_i[IRQ_WIDTH-1:0];
        end
    end

    // Start and stop requests, cleared when carried out or disabled
    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ctl1_ff <= CTL1_RESET;
        end else if (!enable_ff) begin
            ctl1_ff <= CTL1_RESET;
        end else begin
            if (wr_acc && address_i == REG_CONTROL_ONE_IDX) begin
                ctl1_ff <= writedata_i[1:0];
            end
            if (line_state_ff == LINE_START_HOLD && half_done) begin
                ctl1_ff[BIT_START] <= 1'b0;
            end
            if (line_state_ff == LINE_STOP_SETUP && half_done) begin
                ctl1_ff[BIT_STOP] <= 1'b0;
            end
        end
    end

    // Bus occupied flag: set wins over software clear
    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            bb_ff <= 1'b0;
        end else if (!enable_ff) begin
            bb_ff <= 1'b0;
        end else if (start_cond || !sda_sync || !scl_sync) begin
            bb_ff <= 1'b1;
        end else if (stop_cond) begin
            bb_ff <= 1'b0;
        end else if (wr_acc && address_i == REG_CONTROL_STAT_IDX && writedata_i[BIT_BB]) begin
            bb_ff <= 1'b0;
        end
    end

    // Counts cycles with both lines high while flag stays set
    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            idle_cnt_ff  <= '0;
            bus_quiet_ff <= 1'b0;
        end else if (!bb_ff || !sda_sync || !scl_sync) begin
            idle_cnt_ff  <= '0;
            bus_quiet_ff <= 1'b0;
        end else if (idle_cnt_ff == CNT_WIDTH'(BUS_IDLE_CYC - 1)) begin
            bus_quiet_ff <= 1'b1;
        end else begin
            idle_cnt_ff <= idle_cnt_ff + 1'b1;
        end
    end

    // Address phase receiver
    assign addr_byte = {shift_ff[6:0], sda_sync};
    assign addr_done = addr_phase_ff && scl_rise && (bit_cnt_ff == 4'(ADDR_BITS - 1));
    // First bit lands in bit 7, direction bit dropped
    assign id_hit    = own_id_ff[BIT_SLAVE_ID_CHECK_ENABLE] && (addr_byte[7:1] == own_id_ff[6:0]);

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            addr_phase_ff <= 1'b0;
            bit_cnt_ff    <= 4'h0;
            shift_ff      <= 8'h00;
        end else if (!enable_ff || stop_cond || master_ff) begin
            addr_phase_ff <= 1'b0;
            bit_cnt_ff    <= 4'h0;
        end else if (start_cond) begin
            addr_phase_ff <= 1'b1;
            bit_cnt_ff    <= 4'h0;
        end else if (addr_phase_ff && scl_rise) begin
            shift_ff   <= addr_byte;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (addr_done) begin
                addr_phase_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            match_ff <= 1'b0;
        end else if (!enable_ff || start_cond || stop_cond) begin
            match_ff <= 1'b0;
        end else if (addr_done && id_hit) begin
            match_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= enable_ff && (match_ff || master_ff || addr_phase_ff || start_cond
                       || line_state_ff == LINE_START_HOLD);
        end
    end

    // Line sequencer: start, master hold, stop, recovery pulse
    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            line_state_ff <= LINE_IDLE;
            line_cnt_ff   <= '0;
            master_ff     <= 1'b0;
            sda_oe_ff     <= 1'b0;
            scl_oe_ff     <= 1'b0;
        end else if (!enable_ff) begin
            line_state_ff <= LINE_IDLE;
            line_cnt_ff   <= '0;
            master_ff     <= 1'b0;
            sda_oe_ff     <= 1'b0;
            scl_oe_ff     <= 1'b0;
        end else begin
            line_cnt_ff <= half_done ? '0 : line_cnt_ff + 1'b1;
            unique case (line_state_ff)
                LINE_IDLE: begin
                    line_cnt_ff <= '0;
                    if (clock_line_pulse_ff) begin
                        line_state_ff <= LINE_PULSE_LOW;
                        scl_oe_ff     <= 1'b1;
                    end else if (ctl1_ff[BIT_START] && !bb_ff) begin
                        line_state_ff <= LINE_START_HOLD;
                        sda_oe_ff     <= 1'b1;
                    end
                end
                LINE_START_HOLD: if (half_done) begin
                    line_state_ff <= LINE_MASTER;
                    master_ff     <= 1'b1;
                    scl_oe_ff     <= 1'b1;
                end
                LINE_MASTER: begin
                    line_cnt_ff <= '0;
                    if (ctl1_ff[BIT_STOP]) begin
                        line_state_ff <= LINE_STOP_SETUP;
                        sda_oe_ff     <= 1'b1;
                        scl_oe_ff     <= 1'b0;
                    end
                end
                LINE_STOP_SETUP: if (half_done) begin
                    line_state_ff <= LINE_IDLE;
                    sda_oe_ff     <= 1'b0;
                    master_ff     <= 1'b0;
                end
                LINE_PULSE_LOW: if (half_done) begin
                    line_state_ff <= LINE_PULSE_HIGH;
                    scl_oe_ff     <= 1'b0;
                end
                LINE_PULSE_HIGH: if (half_done) begin
                    line_state_ff <= LINE_IDLE;
                end
                default: begin
                    line_state_ff <= LINE_IDLE;
                    sda_oe_ff     <= 1'b0;
                    scl_oe_ff     <= 1'b0;
                end
            endcase
        end
    end

    // Clock pulse request, refused while data line high or as master
    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            clock_line_pulse_ff <= 1'b0;
        end else if (!enable_ff) begin
            clock_line_pulse_ff <= 1'b0;
        end else if (line_state_ff == LINE_PULSE_HIGH && half_done) begin
            clock_line_pulse_ff <= 1'b0;
        end else if (wr_acc && address_i == REG_CONTROL_STAT_IDX && writedata_i[BIT_CLOCK_LINE_PULSE]
                     && !sda_sync && !master_ff && line_state_ff == LINE_IDLE) begin
            clock_line_pulse_ff <= 1'b1;
        end
    end

    // Sticky event bits, write one to clear, set wins
    assign irq_events[IRQ_MATCH]      = addr_done && id_hit && enable_ff;
    assign irq_events[IRQ_START_SENT] = line_state_ff == LINE_START_HOLD && half_done;
    assign irq_events[IRQ_STOP_SEEN]  = stop_cond;
    assign irq_events[IRQ_PULSE_DONE] = line_state_ff == LINE_PULSE_HIGH && half_done;

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            irq_status_ff <= IRQ_RESET;
        end else if (wr_acc && address_i == REG_IRQ_STATUS_IDX) begin
            irq_status_ff <= (irq_status_ff & ~writedata_i[IRQ_WIDTH-1:0]) | irq_events;
        end else begin
            irq_status_ff <= irq_status_ff | irq_events;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign readdata_o    = readdata_ff;
    assign waitrequest_o = waitrequest_ff;
    assign irq_o         = irq_ff;
    assign sda_oe_o      = sda_oe_ff;
    assign scl_oe_o      = scl_oe_ff;
    assign sda_o         = 1'b0;
    assign scl_o         = 1'b0;
endmodule : twowire_own_id_and_recovery

//--- logic/twowire_pkg.sv
// Constants for the two-wire own identity and bus recovery block
package twowire_pkg;
    // Register word indexes (byte address is four times the index)
    localparam logic [2:0] REG_CONTROL_TWO_IDX  = 3'h0;
    localparam logic [2:0] REG_CONTROL_ONE_IDX  = 3'h1;
    localparam logic [2:0] REG_CONTROL_STAT_IDX = 3'h2;
    localparam logic [2:0] REG_OWN_ID_IDX       = 3'h3;
    localparam logic [2:0] REG_STATUS_IDX       = 3'h4;
    localparam logic [2:0] REG_IRQ_STATUS_IDX   = 3'h5;
    localparam logic [2:0] REG_IRQ_MASK_IDX     = 3'h6;

    // control_two_reg
    localparam int BIT_ENABLE     = 0;
    // control_one_reg
    localparam int BIT_START      = 0;
    localparam int BIT_STOP       = 1;
    // control_status_reg
    localparam int BIT_BUSY       = 0;
    localparam int BIT_BB         = 1;
    localparam int BIT_MATCH      = 2;
    localparam int BIT_DATA_LINE_SAMPLE       = 4;
    localparam int BIT_CLOCK_LINE_PULSE      = 5;
    // own_bus_identity
    localparam int BIT_SLAVE_ID_CHECK_ENABLE       = 7;
    // status_reg
    localparam int BIT_MASTER     = 0;
    localparam int BIT_BUS_QUIET  = 1;
    // Interrupt status and mask
    localparam int IRQ_MATCH      = 0;
    localparam int IRQ_START_SENT = 1;
    localparam int IRQ_STOP_SEEN  = 2;
    localparam int IRQ_PULSE_DONE = 3;
    localparam int IRQ_WIDTH      = 4;

    localparam logic [3:0] IRQ_RESET  = 4'h0;
    localparam logic [1:0] CTL1_RESET = 2'h0;

    // Timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int SCL_HALF_NS    = 5000;
    localparam int BUS_IDLE_NS    = 50000;
    localparam int SCL_HALF_CYC   = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_IDLE_CYC   = (BUS_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_WIDTH      = 11;
    localparam int ADDR_BITS      = 8;

    typedef enum logic [2:0] {
        LINE_IDLE       = 3'b000,
        LINE_START_HOLD = 3'b001,
        LINE_MASTER     = 3'b010,
        LINE_STOP_SETUP = 3'b011,
        LINE_PULSE_LOW  = 3'b100,
        LINE_PULSE_HIGH = 3'b101
    } line_state_type;
endpackage : twowire_pkg

//--- logic/level_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module level_sync (
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_ff;
    logic hold_ff;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= 1'b1;
            hold_ff <= 1'b1;
        end else begin
            meta_ff <= async_i;
            hold_ff <= meta_ff;
        end
    end

    assign sync_o = hold_ff;
endmodule : level_sync

//--- verif/twowire_assertions.sv
// Port checks for the own identity and recovery block
`timescale 1ns/10ps
module twowire_assertions
    import twowire_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire logic [2:0]  address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [31:0] readdata_o,
    input wire logic [31:0] writedata_i,
    input wire logic        waitrequest_o,
    input wire logic        sda_i,
    input wire logic        sda_oe_o,
    input wire logic        scl_i,
    input wire logic        scl_oe_o,
    input wire logic        irq_o
);
    logic       ena_ff;
    logic [8:0] id_ff;
    logic       sda_prev_ff;
    logic [2:0] sda_run_ff;
    logic [7:0] scl_run_ff;
    logic       wr_done;
    logic       rd_done;
    assign wr_done = write_i && !waitrequest_o;
    assign rd_done = read_i && !waitrequest_o;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Mirror of software writes
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ena_ff <= 1'b0;
            id_ff  <= 9'h0;
        end else if (wr_done && address_i == REG_CONTROL_TWO_IDX) begin
            ena_ff <= writedata_i[BIT_ENABLE];
        end else if (wr_done && address_i == REG_OWN_ID_IDX) begin
            id_ff  <= {1'b1, writedata_i[7:0]};
        end
    end
    // Run lengths of a steady data line and a held clock line
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_prev_ff <= 1'b1;
            sda_run_ff  <= 3'h0;
            scl_run_ff  <= 8'h0;
        end else begin
            sda_prev_ff <= sda_i;
            sda_run_ff  <= (sda_i != sda_prev_ff) ? 3'h0 : (sda_run_ff == 3'h7 ? 3'h7 : sda_run_ff + 3'h1);
            scl_run_ff  <= !scl_oe_o ? 8'h0 : (scl_run_ff == 8'hFF ? 8'hFF : scl_run_ff + 8'h1);
        end
    end
    a_wait_answer: assert property ($rose(read_i || write_i) |=> !waitrequest_o ##1 waitrequest_o)
        else $error("waitrequest not low for exactly one cycle");
    a_unmapped_zero: assert property (rd_done && address_i == 3'h7 |-> readdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_data_line_sample_level: assert property (rd_done && address_i == REG_CONTROL_STAT_IDX && sda_run_ff == 3'h7
        |-> readdata_o[BIT_DATA_LINE_SAMPLE] == sda_i) else $error("data line sample wrong");
    a_no_match_off: assert property (rd_done && address_i == REG_CONTROL_STAT_IDX && !id_ff[7]
        |-> !readdata_o[BIT_MATCH]) else $error("match with check disabled");
    a_id_readback: assert property (rd_done && address_i == REG_OWN_ID_IDX && id_ff[8]
        |-> readdata_o[7:0] == id_ff[7:0]) else $error("identity readback wrong");
    a_disabled_clear: assert property (rd_done && address_i == REG_CONTROL_STAT_IDX && !ena_ff
        |-> readdata_o[2:0] == 3'h0) else $error("status bits set while disabled");
    a_disabled_idle: assert property (!ena_ff && !$past(ena_ff) |-> !sda_oe_o && !scl_oe_o)
        else $error("lines driven while disabled");
    a_start_free: assert property ($rose(sda_oe_o) |-> $past(sda_i, 3) && $past(scl_i, 3))
        else $error("start on occupied bus");
    a_start_hold: assert property ($rose(sda_oe_o) |-> (sda_oe_o && !scl_oe_o) [*8])
        else $error("clock pulled too soon after start");
    a_pulse_low: assert property ($rose(scl_oe_o) && !sda_oe_o |-> !$past(sda_i, 4))
        else $error("clock pulse with data line high");
    a_pulse_width: assert property ($fell(scl_oe_o) && !sda_oe_o |-> scl_run_ff >= SCL_HALF_CYC)
        else $error("clock pulse too short");
    c_match: cover property (rd_done && address_i == REG_CONTROL_STAT_IDX && readdata_o[BIT_MATCH]);
    c_pulse: cover property ($fell(scl_oe_o) && !sda_oe_o);
    c_irq: cover property ($rose(irq_o));
endmodule : twowire_assertions

//--- verif/bus_partner.sv
// Behavioural far side: another master and a stuck slave
`timescale 1ns/10ps
module bus_partner (
    input  wire logic scl_i,
    output logic      sda_pull_o,
    output logic      scl_pull_o
);
    localparam int HALF_NS = 200;
    initial begin
        sda_pull_o = 1'b0;
        scl_pull_o = 1'b0;
    end
    // Start, then address byte MSB first; clock left low
    task automatic send_addr(input logic [7:0] b);
        sda_pull_o = 1'b1;
        #HALF_NS scl_pull_o = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            sda_pull_o = !b[i];
            #HALF_NS scl_pull_o = 1'b0;
            #HALF_NS scl_pull_o = 1'b1;
        end
    endtask : send_addr
    task automatic send_stop();
        sda_pull_o = 1'b1;
        #HALF_NS scl_pull_o = 1'b0;
        #HALF_NS sda_pull_o = 1'b0;
        #HALF_NS;
    endtask : send_stop
    // Slave out of step: holds data low for n clock falls
    task automatic stick(input int n);
        sda_pull_o = 1'b1;
        repeat (n) @(negedge scl_i);
        #HALF_NS sda_pull_o = 1'b0;
    endtask : stick
endmodule : bus_partner

//--- verif/tb_top.sv
// Testbench for the own identity and recovery block
`timescale 1ns/10ps
module tb_top;
    import twowire_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [2:0]  address_i = 3'h0;
    logic        read_i = 1'b0;
    logic        write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [31:0] readdata_o;
    logic        waitrequest_o, sda_o, sda_oe_o, scl_o, scl_oe_o, irq_o;
    logic        sda_pull, scl_pull, sda_i, scl_i;
    int          mismatches = 0;
    int          check_count = 0;
    int          pulses = 0;
    logic [31:0] d;
    // Open-drain lines with pull-ups
    assign sda_i = !(sda_oe_o || sda_pull);
    assign scl_i = !(scl_oe_o || scl_pull);
    always #25 core_clk_i = !core_clk_i;
    always @(posedge scl_oe_o) if (!sda_oe_o) pulses++;
    twowire_own_id_and_recovery dut (.core_clk_i, .reset_n_i, .address_i, .read_i, .write_i, .writedata_i,
        .readdata_o, .waitrequest_o, .sda_i, .sda_o, .sda_oe_o, .scl_i, .scl_o, .scl_oe_o, .irq_o);
    bus_partner bp (.scl_i(scl_i), .sda_pull_o(sda_pull), .scl_pull_o(scl_pull));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk_i);
        address_i   <= a;
        writedata_i <= wd;
        write_i     <= wr;
        read_i      <= !wr;
        // Waits for the slave; only the watchdog ends a hang
        do begin
            @(posedge core_clk_i);
        end while (waitrequest_o !== 1'b0);
        rd = readdata_o;
        write_i <= 1'b0;
        read_i  <= 1'b0;
    endtask : bus
    task automatic poll(input logic [2:0] a, input int b, input logic v, input string what);
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 32'h0, r);
            n++;
        end while (r[b] !== v && n < 500);
        chk(what, {31'h0, v}, {31'h0, r[b]});
    endtask : poll
    task automatic test_regs();
        bus(1'b1, REG_OWN_ID_IDX, 32'h000000C3, d);
        bus(1'b0, REG_OWN_ID_IDX, 32'h0, d);
        chk("own identity", 32'hC3, {24'h0, d[7:0]});
        bus(1'b1, REG_CONTROL_STAT_IDX, 32'h10, d);
        bus(1'b0, REG_CONTROL_STAT_IDX, 32'h0, d);
        chk("data line sample", 32'h1, {31'h0, d[BIT_DATA_LINE_SAMPLE]});
        bus(1'b0, 3'h7, 32'h0, d);
        chk("unmapped read", 32'h0, d);
        bus(1'b0, REG_CONTROL_ONE_IDX, 32'h0, d);
        chk("control one reset", {30'h0, CTL1_RESET}, d);
        $display("test regs done");
    endtask : test_regs
    task automatic test_match(input logic [7:0] id, input logic [7:0] abyte, input logic exp);
        bus(1'b1, REG_OWN_ID_IDX, {24'h0, id}, d);
        bus(1'b1, REG_IRQ_STATUS_IDX, 32'hF, d);
        bus(1'b1, REG_IRQ_MASK_IDX, 32'h1 << IRQ_MATCH, d);
        bp.send_addr(abyte);
        bus(1'b0, REG_CONTROL_STAT_IDX, 32'h0, d);
        chk("match", {31'h0, exp}, {31'h0, d[BIT_MATCH]});
        chk("bus occupied", 32'h1, {31'h0, d[BIT_BB]});
        chk("busy after address", {31'h0, exp}, {31'h0, d[BIT_BUSY]});
        chk("irq raised", {31'h0, exp}, {31'h0, irq_o});
        bus(1'b1, REG_IRQ_MASK_IDX, 32'h0, d);
        bus(1'b0, REG_IRQ_STATUS_IDX, 32'h0, d);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        chk("irq status", {31'h0, exp}, {31'h0, d[IRQ_MATCH]});
        bus(1'b1, REG_IRQ_STATUS_IDX, 32'h1 << IRQ_MATCH, d);
        bus(1'b0, REG_IRQ_STATUS_IDX, 32'h0, d);
        chk("irq cleared", 32'h0, {31'h0, d[IRQ_MATCH]});
        bp.send_stop();
        bus(1'b0, REG_CONTROL_STAT_IDX, 32'h0, d);
        chk("match after stop", 32'h0, {29'h0, d[BIT_MATCH], d[BIT_BB], 1'b0});
        $display("test match done");
    endtask : test_match
    task automatic test_disable();
        bp.send_addr(8'h00);
        bus(1'b1, REG_CONTROL_TWO_IDX, 32'h0, d);
        bus(1'b0, REG_CONTROL_STAT_IDX, 32'h0, d);
        chk("disabled status", 32'h0, {29'h0, d[2:0]});
        bp.send_stop();
        bus(1'b1, REG_CONTROL_TWO_IDX, 32'h1, d);
        bus(1'b0, REG_CONTROL_STAT_IDX, 32'h0, d);
        chk("occupied after enable", 32'h0, {31'h0, d[BIT_BB]});
        $display("test disable done");
    endtask : test_disable
    task automatic test_recovery();
        pulses = 0;
        fork
            bp.stick(2);
        join_none
        bus(1'b1, REG_CONTROL_TWO_IDX, 32'h0, d);
        bus(1'b1, REG_CONTROL_TWO_IDX, 32'h1, d);
        bus(1'b1, REG_CONTROL_ONE_IDX, 32'h1 << BIT_START, d);
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, REG_CONTROL_STAT_IDX, 32'h0, d);
            if (d[BIT_DATA_LINE_SAMPLE]) break;
            bus(1'b1, REG_CONTROL_STAT_IDX, 32'h1 << BIT_CLOCK_LINE_PULSE, d);
            poll(REG_CONTROL_STAT_IDX, BIT_CLOCK_LINE_PULSE, 1'b0, "pulse self clear");
            poll(REG_STATUS_IDX, BIT_MASTER, 1'b0, "master during recovery");
        end
        bus(1'b1, REG_CONTROL_STAT_IDX, 32'h1 << BIT_CLOCK_LINE_PULSE, d);
        bus(1'b0, REG_CONTROL_STAT_IDX, 32'h0, d);
        chk("pulse ignored", 32'h1, {30'h0, d[BIT_CLOCK_LINE_PULSE], d[BIT_BB]});
        chk("pulse count", 32'h2, pulses);
        repeat (BUS_IDLE_CYC + 100) @(posedge core_clk_i);
        bus(1'b0, REG_STATUS_IDX, 32'h0, d);
        chk("bus quiet", 32'h2, {30'h0, d[BIT_BUS_QUIET], d[BIT_MASTER]});
        bus(1'b1, REG_CONTROL_STAT_IDX, 32'h1 << BIT_BB, d);
        poll(REG_STATUS_IDX, BIT_MASTER, 1'b1, "start sent");
        bus(1'b1, REG_CONTROL_ONE_IDX, 32'h1 << BIT_STOP, d);
        poll(REG_STATUS_IDX, BIT_MASTER, 1'b0, "master after stop");
        poll(REG_CONTROL_STAT_IDX, BIT_BB, 1'b0, "occupied after stop");
        $display("test recovery done");
    endtask : test_recovery
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        #1000000;
        mismatches++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        test_regs();
        bus(1'b1, REG_CONTROL_TWO_IDX, 32'h1, d);
        test_match(8'hDA, 8'hB5, 1'b1);
        test_match(8'hDA, 8'hB4, 1'b1);
        test_match(8'hDA, 8'hB7, 1'b0);
        test_match(8'hDA, 8'h35, 1'b0);
        test_match(8'h5A, 8'hB5, 1'b0);
        test_disable();
        test_recovery();
        final_report();
    end
endmodule : tb_top
bind twowire_own_id_and_recovery twowire_assertions chk_i (.core_clk_i, .reset_n_i, .address_i, .read_i,
    .write_i, .readdata_o, .writedata_i, .waitrequest_o, .sda_i, .sda_oe_o, .scl_i, .scl_oe_o, .irq_o);
